//--- design/vic_core.sv
// Vectored interrupt controller with nesting and per-vector source choice
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "vic_defs.svh"

module vic_core
  import vic_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  input  wire logic [`VIC_RADDR_W-1:0]    reg_addr,
  input  wire logic [`VIC_DATA_W-1:0]     reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [`VIC_DATA_W-1:0]     reg_rdata,
  input  wire logic [`VIC_VEC_N-1:0]      fixed_irq,
  input  wire logic [`VIC_DMA_HALF-1:0]   dma_term_out_low,
  input  wire logic [`VIC_DMA_HALF-1:0]   dma_term_out_high,
  input  wire logic [`VIC_VEC_N-1:0]      routed_irq,
  input  wire logic                       irq_ack,
  input  wire logic                       return_from_interrupt_instr,
  output logic                            irq_req,
  output logic      [`VIC_NUM_W-1:0]      irq_num,
  output logic      [`VIC_CADDR_W-1:0]    irq_addr
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  localparam state_type STATE_RST = '{fsm: ST_IDLE, default: '0};

  // Vectors that have a hard-wired fixed source
  localparam logic [`VIC_VEC_N-1:0] FIXED_WIRED = `VIC_FIXED_WIRED;

  // Index of a per-vector bank register, valid flag on top
  function automatic logic [5:0] bank_hit(input logic [`VIC_RADDR_W-1:0] a,
                                          input logic [1:0]              bank);
    bank_hit = {(a[9:8] == bank) && !a[7] && (a[1:0] == 2'h0), a[6:2]};
  endfunction : bank_hit

  // Most urgent active level, or none
  function automatic logic [3:0] top_level(input logic [`VIC_LVL_N-1:0] act);
    top_level = `VIC_NO_LEVEL;
    for (int i = `VIC_LVL_N - 1; i >= 0; i--)
    begin
      if (act[i])
      begin
        top_level = 4'(i);
      end
    end
  endfunction : top_level

  //////////////////////////////////////////////////////////////////////////////
  // State

  state_type s_q;
  state_type s_d;

  logic [`VIC_VEC_N-1:0] src_now;
  logic [`VIC_VEC_N-1:0] cand;
  pick_type              pick;

  //////////////////////////////////////////////////////////////////////////////
  // Source selection per vector

  for (genvar v = 0; v < `VIC_VEC_N; v++)
  begin : g_src
    logic dma_bit;
    logic fixed_bit;
    if (v < `VIC_DMA_HALF)
    begin : g_lo
      assign dma_bit = dma_term_out_low[v];
    end
    else
    begin : g_hi
      assign dma_bit = dma_term_out_high[v - `VIC_DMA_HALF];
    end
    assign fixed_bit = fixed_irq[v] & FIXED_WIRED[v];
    always_comb
    begin
      case (s_q.sel[v])
        `VIC_SRC_FIXED:  src_now[v] = fixed_bit;
        `VIC_SRC_DMA:    src_now[v] = dma_bit;
        `VIC_SRC_ROUTED: src_now[v] = routed_irq[v];
        default:         src_now[v] = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration

  vic_picker #(
    .N  (`VIC_VEC_N),
    .PW (`VIC_PRIO_W)
  ) u_picker (
    .req  (cand),
    .prio (s_d.prio),
    .pick (pick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [5:0]            hit;
    logic [`VIC_VEC_N-1:0] set_sw;
    logic [`VIC_VEC_N-1:0] clr_all;
    logic [`VIC_VEC_N-1:0] rise;
    logic [3:0]            cur;
    logic                  take;
    hit     = '0;
    set_sw  = '0;
    clr_all = '0;
    rise    = '0;
    cur     = '0;
    take    = 1'b0;
    s_d     = s_q;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `VIC_OFS_ENABLE: s_d.enable = reg_wdata;
        `VIC_OFS_PSET:   set_sw     = reg_wdata;
        `VIC_OFS_PCLR:   clr_all    = reg_wdata;
        default:         ;
      endcase
      hit = bank_hit(reg_addr, `VIC_BANK_PRIO);
      if (hit[5])
      begin
        s_d.prio[hit[4:0]] = reg_wdata[`VIC_PRIO_W-1:0];
      end
      hit = bank_hit(reg_addr, `VIC_BANK_ADDR);
      if (hit[5])
      begin
        s_d.vaddr[hit[4:0]] = reg_wdata[`VIC_CADDR_W-1:0];
      end
      hit = bank_hit(reg_addr, `VIC_BANK_SEL);
      if (hit[5])
      begin
        s_d.sel[hit[4:0]] = reg_wdata[`VIC_SEL_W-1:0];
      end
    end

    // Acknowledge retires the offered vector and opens its level
    if (irq_ack && s_q.req)
    begin
      clr_all[s_q.num] = 1'b1;
      s_d.active[s_q.prio[s_q.num]] = 1'b1;
    end

    // Return closes the most urgent open level
    if (return_from_interrupt_instr)
    begin
      s_d.active = s_d.active & (s_d.active - 8'h01);
    end

    // Latch rising requests; a set wins over a clear
    rise         = src_now & ~s_q.src_prev;
    s_d.src_prev = src_now;
    s_d.pending  = (s_q.pending & ~clr_all) | rise | set_sw;

    cand = s_d.pending & s_d.enable;
    cur  = top_level(s_d.active);
    take = pick.valid && ({1'b0, pick.prio} < cur);

    // Offer to the core
    case (s_q.fsm)
      ST_IDLE:
      begin
        if (take)
        begin
          s_d.fsm  = ST_OFFER;
          s_d.req  = 1'b1;
          s_d.num  = pick.num;
          s_d.addr = s_d.vaddr[pick.num];
        end
      end
      ST_OFFER:
      begin
        if (irq_ack)
        begin
          s_d.fsm = ST_IDLE;
          s_d.req = 1'b0;
        end
        else if (take)
        begin
          s_d.num  = pick.num;
          s_d.addr = s_d.vaddr[pick.num];
        end
        else
        begin
          s_d.fsm = ST_IDLE;
          s_d.req = 1'b0;
        end
      end
      default:
      begin
        s_d.fsm = ST_IDLE;
        s_d.req = 1'b0;
      end
    endcase

    // Read data, one cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `VIC_OFS_ENABLE: s_d.rdata = s_q.enable;
        `VIC_OFS_PSET:   s_d.rdata = s_q.pending;
        `VIC_OFS_PCLR:   s_d.rdata = s_q.pending;
        `VIC_OFS_STATUS: s_d.rdata = {15'h0000, s_q.req, s_q.active, 3'h0, s_q.num};
        default:         ;
      endcase
      hit = bank_hit(reg_addr, `VIC_BANK_PRIO);
      if (hit[5])
      begin
        s_d.rdata = {29'h0000_0000, s_q.prio[hit[4:0]]};
      end
      hit = bank_hit(reg_addr, `VIC_BANK_ADDR);
      if (hit[5])
      begin
        s_d.rdata = {16'h0000, s_q.vaddr[hit[4:0]]};
      end
      hit = bank_hit(reg_addr, `VIC_BANK_SEL);
      if (hit[5])
      begin
        s_d.rdata = {30'h0000_0000, s_q.sel[hit[4:0]]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= STATE_RST;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_req   = s_q.req;
  assign irq_num   = s_q.num;
  assign irq_addr  = s_q.addr;

endmodule : vic_core

//--- design/vic_defs.svh
// Register map, encodings and widths of the vectored interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define VIC_VEC_N        32
`define VIC_PRIO_W       3
`define VIC_LVL_N        8
`define VIC_NUM_W        5
`define VIC_CADDR_W      16
`define VIC_SEL_W        2
`define VIC_RADDR_W      10
`define VIC_DATA_W       32
`define VIC_DMA_HALF     16

`define VIC_OFS_ENABLE   10'h000
`define VIC_OFS_PSET     10'h004
`define VIC_OFS_PCLR     10'h008
`define VIC_OFS_STATUS   10'h00c
`define VIC_BANK_CTRL    2'h0
`define VIC_BANK_PRIO    2'h1
`define VIC_BANK_ADDR    2'h2
`define VIC_BANK_SEL     2'h3

`define VIC_SRC_FIXED    2'h0
`define VIC_SRC_DMA      2'h1
`define VIC_SRC_ROUTED   2'h2
`define VIC_SRC_NONE     2'h3

`define VIC_FIXED_WIRED  32'he3ff_fffb
`define VIC_NO_LEVEL     4'h8

`endif

//--- design/vic_picker.sv
// Picks the most urgent pending vector, lowest number on a tie
`timescale 1ns/10ps
`include "vic_defs.svh"

module vic_picker
  import vic_pkg::*;
#(
  parameter int N  = `VIC_VEC_N,
  parameter int PW = `VIC_PRIO_W
)
(
  input  wire logic [N-1:0]         req,
  input  wire logic [N-1:0][PW-1:0] prio,
  output pick_type                  pick
);

  always_comb
  begin
    pick = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i] && (!pick.valid || prio[i] <= pick.prio))
      begin
        pick.valid = 1'b1;
        pick.num   = 5'(i);
        pick.prio  = prio[i];
      end
    end
  end

endmodule : vic_picker

//--- design/vic_pkg.sv
// Types shared by the interrupt controller modules
package vic_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OFFER = 2'b10
  } fsm_type;

  typedef struct packed {
    logic                   valid;
    logic [4:0]             num;
    logic [2:0]             prio;
  } pick_type;

  typedef struct packed {
    fsm_type                fsm;
    logic [31:0]            enable;
    logic [31:0]            pending;
    logic [31:0]            src_prev;
    logic [7:0]             active;
    logic [31:0][2:0]       prio;
    logic [31:0][15:0]      vaddr;
    logic [31:0][1:0]       sel;
    logic                   req;
    logic [4:0]             num;
    logic [15:0]            addr;
    logic [31:0]            rdata;
  } state_type;

endpackage : vic_pkg

//--- test/vic_core_props.sv
// Port assertions for the interrupt controller
`timescale 1ns/10ps
module vic_core_props
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [9:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq_ack,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_num,
  input wire logic [15:0] irq_addr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ack_drop_a: assert property (irq_req && irq_ack && ce |=> !irq_req)
    else $error("offer kept after ack");
  offer_hold_a: assert property (irq_req && !irq_ack && !reg_wr && ce |=> irq_req)
    else $error("offer dropped");
  fall_cause_a: assert property ($fell(irq_req) |-> $past(irq_ack) || $past(reg_wr))
    else $error("offer fell alone");
  addr_hold_a: assert property (irq_req && $past(irq_req) && $stable(irq_num)
    && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(irq_addr)) else $error("addr moved");
  rd_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside slot");
  status_a: assert property (ce && reg_rd && reg_addr == 10'h00c |=>
    reg_rdata[16] == $past(irq_req) && reg_rdata[4:0] == $past(irq_num)) else $error("status wrong");
  reset_quiet_a: assert property ($rose(nrst) |-> !irq_req && irq_num == 5'h0 && irq_addr == 16'h0)
    else $error("outputs after reset");
  freeze_a: assert property (!ce |=> $stable(irq_req) && $stable(irq_num) && $stable(irq_addr))
    else $error("moved while frozen");
  cover property (irq_req && irq_ack);
  cover property (!ce);
  cover property (reg_rd && reg_addr == 10'h00c);
endmodule : vic_core_props
bind vic_core vic_core_props props_u (.core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_num(irq_num), .irq_addr(irq_addr));

//--- test/vic_core_tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module vic_core_tb_top;
  logic        core_clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, ret_go = 0;
  logic [9:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, fixed_irq = 0, routed_irq = 0, reg_rdata;
  logic [15:0] dma_term_out_low = 0, dma_term_out_high = 0, irq_addr, got_addr;
  logic [4:0]  irq_num, got_num;
  logic [3:0]  lag = 0;
  logic [7:0]  taken;
  logic        irq_ack, ret_pulse, irq_req;
  int          miscompares = 0, tests_run = 0;
  initial forever #25 core_clk = ~core_clk;
  vic_core dut_u (.core_clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fixed_irq,
    .dma_term_out_low, .dma_term_out_high, .routed_irq, .irq_ack, .return_from_interrupt_instr(ret_pulse),
    .irq_req, .irq_num, .irq_addr);
  vic_cpu_model cpu_u (.core_clk, .nrst, .irq_req, .irq_num, .irq_addr, .ret_go, .lag, .irq_ack,
    .ret_pulse, .got_num, .got_addr, .taken);
  ////////////////////////////////////////////////////////////////
  task end_sim;
    $display("Compared %0d, mismatched %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask : cmp
  task wr(input logic [9:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata & m, e);
    @(posedge core_clk);
  endtask : rd
  task take(input logic [4:0] n, input logic [15:0] a);
    logic [7:0] t0;
    t0 = taken;
    for (int i = 0; i < 40 && taken === t0; i++)
      @(posedge core_clk);
    #1 if (taken === t0)
    begin
      miscompares++;
      end_sim();
    end
    cmp({27'h0, got_num}, {27'h0, n});
    cmp({16'h0, got_addr}, {16'h0, a});
  endtask : take
  task ret;
    ret_go <= 1'b1;
    @(posedge core_clk);
    ret_go <= 1'b0;
    @(posedge core_clk);
  endtask : ret
  task pulse(input int c, input int v);
    logic [31:0] m;
    m = 32'h1 << v;
    fixed_irq         <= c == 0 ? m : 32'h0;
    dma_term_out_low  <= c == 1 ? m[15:0] : 16'h0;
    dma_term_out_high <= c == 1 ? m[31:16] : 16'h0;
    routed_irq        <= c == 2 ? m : 32'h0;
    @(posedge core_clk);
    {fixed_irq, routed_irq, dma_term_out_low, dma_term_out_high} <= '0;
    @(posedge core_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rd(10'h17c, '1, 32'h0);
    wr(10'h180, 32'hffff_ffff);
    rd(10'h180, '1, 32'h0);
    rd(10'h000, '1, 32'h0);
    ce <= 1'b0;
    repeat (3) @(posedge core_clk);
    ce <= 1'b1;
    cmp({31'h0, irq_req}, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_soft;
    logic [7:0] t0;
    wr(10'h000, 32'h0000_0220);
    wr(10'h214, 32'h0000_1234);
    wr(10'h224, 32'h0000_5678);
    wr(10'h004, 32'h0000_0228);
    take(5'd5, 16'h1234);
    t0 = taken;
    repeat (10) @(posedge core_clk);
    cmp({24'h0, taken}, {24'h0, t0});
    ret();
    take(5'd9, 16'h5678);
    ret();
    rd(10'h004, '1, 32'h8);
    wr(10'h008, 32'h8);
    rd(10'h004, '1, 32'h0);
    $display("software test done");
  endtask : t_soft
  task t_nest;
    lag <= 4'h3;
    wr(10'h000, 32'h0003_fc00);
    for (int i = 0; i < 8; i++)
      wr(10'(10'h128 + 4 * i), 32'(7 - i));
    for (int i = 0; i < 8; i++)
    begin
      wr(10'h004, 32'h400 << i);
      take(5'(10 + i), 16'h0);
    end
    rd(10'h00c, 32'h0001_ff00, 32'h0000_ff00);
    repeat (8) ret();
    rd(10'h00c, 32'h0001_ff00, 32'h0);
    $display("nesting test done");
  endtask : t_nest
  task t_src;
    int v;
    wr(10'h000, 32'h0);
    for (int j = 0; j < 2; j++)
      for (int c = 0; c < 3; c++)
      begin
        v = j * 16 + 4;
        wr(10'(10'h300 + 4 * v), 32'(c));
        pulse((c + 1) % 3, v);
        pulse((c + 2) % 3, v);
        rd(10'h004, '1, 32'h0);
        pulse(c, v);
        rd(10'h004, '1, 32'h1 << v);
        wr(10'h000, 32'h1 << v);
        take(5'(v), 16'h0);
        wr(10'h000, 32'h0);
        ret();
      end
    pulse(0, 27);
    rd(10'h004, '1, 32'h0);
    $display("source test done");
  endtask : t_src
  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_soft();
    t_nest();
    t_src();
    end_sim();
  end
endmodule : vic_core_tb_top

//--- test/vic_cpu_model.sv
// Core side: acknowledges offers, returns on command
`timescale 1ns/10ps
module vic_cpu_model
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_num,
  input wire logic [15:0] irq_addr,
  input wire logic        ret_go,
  input wire logic [3:0]  lag,
  output logic            irq_ack,
  output logic            ret_pulse,
  output logic [4:0]      got_num,
  output logic [15:0]     got_addr,
  output logic [7:0]      taken
);
  logic [3:0] wait_q;
  assign ret_pulse = ret_go; // Pops PC, resumes
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      wait_q  <= 4'h0;
      irq_ack <= 1'b0;
      taken   <= 8'h0;
    end
    else if (irq_req && !irq_ack && wait_q >= lag) // Instruction done, PC pushed
      irq_ack <= 1'b1;
    else
    begin
      irq_ack <= 1'b0;
      wait_q  <= irq_req ? wait_q + 4'h1 : 4'h0;
      if (irq_ack && irq_req) // Jump to offered vector
      begin
        got_num  <= irq_num;
        got_addr <= irq_addr;
        taken    <= taken + 8'h1;
        wait_q   <= 4'h0;
      end
    end
endmodule : vic_cpu_model
